// ===== core/tws_pkg.sv
// shared constants, types and states of the trigger wait status block
// assumes a single 100 MHz clock and pin level trigger inputs
package tws_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned READOUT_NS    = 12500;
    localparam int unsigned READOUT_CYC   = (READOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W         = 16;
    localparam logic [CNT_W-1:0] READOUT_LOAD = CNT_W'(READOUT_CYC);

    // ****************************************************************
    // indices, widths, reset values
    // ****************************************************************
    localparam int N_TRIG     = 3;
    localparam int TRIG_ACQ   = 0;
    localparam int TRIG_FRAME = 1;
    localparam int TRIG_LINE  = 2;
    localparam int N_OUT      = 2;
    localparam int OUT_SEL_W  = 1;
    localparam int FRM_W      = 8;

    localparam logic             BIT_RST  = 1'b0;
    localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
    localparam logic [FRM_W-1:0] FRM_RST  = 8'h00;
    localparam logic [FRM_W-1:0] FRM_ONE  = 8'h01;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {SRC_OFF, SRC_ACQ_WAIT, SRC_FRAME_WAIT, SRC_LINE_WAIT} tws_src_t;
    typedef enum logic {EXPO_TIMED, EXPO_TRIG_WIDTH} tws_expo_t;
    typedef enum {A_IDLE, A_WAIT, A_RUN} tws_acq_st_t;
    typedef enum {F_IDLE, F_WAIT, F_RUN} tws_frm_st_t;
    typedef enum {L_IDLE, L_GAP, L_WAIT, L_EXPO} tws_lin_st_t;

    localparam tws_src_t OUT_SRC_RST [N_OUT] = '{SRC_OFF, SRC_FRAME_WAIT};

    typedef struct packed {
        logic [N_TRIG-1:0] hw_trig_en;
        logic [N_TRIG-1:0] trig_falling;
        tws_expo_t         expo_mode;
        logic [CNT_W-1:0]  exposure_duration_setting;
        logic [CNT_W-1:0]  max_overlap_exposure_setting;
        logic [FRM_W-1:0]  frames_per_acq;
        logic [CNT_W-1:0]  lines_per_frame;
    } tws_cfg_t;

endpackage

// ===== core/tws_trig_sync.sv
// two-stage synchroniser and active edge detector for one trigger pin
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ps
module tws_trig_sync (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic trig_i,
    input  wire logic falling_i,
    output logic      level_o,
    output logic      edge_o
);

    logic meta_r;
    logic sync_r;
    logic lvl_r;
    logic edge_r;
    logic lvl_nxt;
    logic edge_nxt;
    logic [2:0] arm_r;
    logic [2:0] arm_nxt;

    // ****************************************************************
    // edge detect
    // ****************************************************************
    // toggling falling_i mid-stream can fake one edge; change it while idle
    // lvl_r is only trustworthy three edges after reset; a falling-edge pin idles
    // high, so an unguarded detector would see a false edge right after reset
    always_comb begin
        arm_nxt  = {arm_r[1:0], 1'b1};
        lvl_nxt  = sync_r ^ falling_i;
        edge_nxt = lvl_nxt & ~lvl_r & arm_r[2];
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            meta_r <= tws_pkg::BIT_RST;
            sync_r <= tws_pkg::BIT_RST;
            lvl_r  <= tws_pkg::BIT_RST;
            edge_r <= tws_pkg::BIT_RST;
            arm_r  <= 3'h0;
        end else begin
            meta_r <= trig_i;
            sync_r <= meta_r;
            lvl_r  <= lvl_nxt;
            edge_r <= edge_nxt;
            arm_r  <= arm_nxt;
        end
    end

    assign level_o = lvl_r;
    assign edge_o  = edge_r;

endmodule // tws_trig_sync

// ===== core/tws_trigger_wait.sv
// acquisition, frame and line wait status generation with output routing
// assumes trigger pins asynchronous, configuration static while acquiring
`timescale 1ns/1ps
module tws_trigger_wait (
    input  wire logic                         CLOCK_I,
    input  wire logic                         RESETN_I,
    input  wire tws_pkg::tws_cfg_t            CONFIG_I,
    input  wire logic                         ACQ_ENABLE_I,
    input  wire logic                         EXT_ACQUISITION_START_TRIGGER_I,
    input  wire logic                         EXT_FRAME_START_TRIGGER_I,
    input  wire logic                         EXT_LINE_START_TRIGGER_I,
    input  wire logic [tws_pkg::OUT_SEL_W-1:0] OUTPUT_PIN_SELECTOR_I,
    input  wire tws_pkg::tws_src_t            OUTPUT_PIN_SOURCE_I,
    input  wire logic                         OUTPUT_PIN_SOURCE_WE_I,
    output logic                              ACQ_WAIT_O,
    output logic                              FRAME_WAIT_O,
    output logic                              LINE_WAIT_O,
    output logic                              ACQ_OVERTRIG_O,
    output logic                              FRAME_OVERTRIG_O,
    output logic                              LINE_OVERTRIG_O,
    output logic [tws_pkg::N_OUT-1:0]         OUTPUT_LINES_O
);

    localparam int TA = tws_pkg::TRIG_ACQ;
    localparam int TF = tws_pkg::TRIG_FRAME;
    localparam int TL = tws_pkg::TRIG_LINE;

    logic [tws_pkg::N_TRIG-1:0] trig_raw;
    logic [tws_pkg::N_TRIG-1:0] trig_lvl;
    logic [tws_pkg::N_TRIG-1:0] trig_edge;
    logic [tws_pkg::N_TRIG-1:0] hw_en;
    logic [tws_pkg::N_TRIG-1:0] hw_edge;

    tws_pkg::tws_acq_st_t      acq_st_r;
    tws_pkg::tws_acq_st_t      acq_st_nxt;
    logic [tws_pkg::FRM_W-1:0] frames_left_r;
    logic [tws_pkg::FRM_W-1:0] frames_left_nxt;
    tws_pkg::tws_frm_st_t      frm_st_r;
    tws_pkg::tws_frm_st_t      frm_st_nxt;
    logic [tws_pkg::CNT_W-1:0] lines_left_r;
    logic [tws_pkg::CNT_W-1:0] lines_left_nxt;
    tws_pkg::tws_lin_st_t      lin_st_r;
    tws_pkg::tws_lin_st_t      lin_st_nxt;
    logic [tws_pkg::CNT_W-1:0] exp_cnt_r;
    logic [tws_pkg::CNT_W-1:0] exp_cnt_nxt;
    logic [tws_pkg::CNT_W-1:0] rd_cnt_r;
    logic [tws_pkg::CNT_W-1:0] rd_cnt_nxt;

    logic                      acq_take;
    logic                      frm_take;
    logic                      lin_take;
    logic                      width_mode;
    logic [tws_pkg::CNT_W-1:0] lead;
    logic                      headroom;
    logic                      expo_end;
    logic                      frame_done;

    logic [2:0]                wait_r;
    logic [2:0]                wait_nxt;
    logic [2:0]                ovt_r;
    logic [2:0]                ovt_nxt;
    tws_pkg::tws_src_t         src_r   [tws_pkg::N_OUT];
    tws_pkg::tws_src_t         src_nxt [tws_pkg::N_OUT];
    logic [tws_pkg::N_OUT-1:0] out_r;
    logic [tws_pkg::N_OUT-1:0] out_nxt;

    // ****************************************************************
    // trigger inputs
    // ****************************************************************
    assign trig_raw = {EXT_LINE_START_TRIGGER_I, EXT_FRAME_START_TRIGGER_I,
                       EXT_ACQUISITION_START_TRIGGER_I};
    assign hw_en    = CONFIG_I.hw_trig_en;
    assign hw_edge  = trig_edge & hw_en;

    generate
        for (genvar g = 0; g < tws_pkg::N_TRIG; g++) begin : g_sync
            tws_trig_sync u_sync (
                .clk_i     (CLOCK_I),
                .rstn_i    (RESETN_I),
                .trig_i    (trig_raw[g]),
                .falling_i (CONFIG_I.trig_falling[g]),
                .level_o   (trig_lvl[g]),
                .edge_o    (trig_edge[g])
            );
        end
    endgenerate

    // a disabled hardware trigger means the wait is left at once, internally
    assign acq_take = (acq_st_r == tws_pkg::A_WAIT) && (hw_en[TA] ? hw_edge[TA] : 1'b1);
    assign frm_take = (frm_st_r == tws_pkg::F_WAIT) && (hw_en[TF] ? hw_edge[TF] : 1'b1);
    assign lin_take = (lin_st_r == tws_pkg::L_WAIT) && (hw_en[TL] ? hw_edge[TL] : 1'b1);

    // ****************************************************************
    // line timing
    // ****************************************************************
    // width mode needs a real trigger pulse; internal lines fall back to timed
    assign width_mode = (CONFIG_I.expo_mode == tws_pkg::EXPO_TRIG_WIDTH) && hw_en[TL];
    assign lead       = width_mode ? CONFIG_I.max_overlap_exposure_setting
                                   : CONFIG_I.exposure_duration_setting;
    assign headroom   = (rd_cnt_r <= lead);
    // exposure may not end before the previous readout is free
    assign expo_end   = (lin_st_r == tws_pkg::L_EXPO) && (rd_cnt_r <= tws_pkg::CNT_ONE) &&
                        (width_mode ? !trig_lvl[TL] : (exp_cnt_r <= tws_pkg::CNT_ONE));
    assign frame_done = expo_end && (lines_left_r <= tws_pkg::CNT_ONE);

    // ****************************************************************
    // acquisition state
    // ****************************************************************
    always_comb begin
        acq_st_nxt      = acq_st_r;
        frames_left_nxt = frames_left_r;
        case (acq_st_r)
            tws_pkg::A_IDLE: begin
                if (ACQ_ENABLE_I) begin
                    acq_st_nxt = tws_pkg::A_WAIT;
                end
            end
            tws_pkg::A_WAIT: begin
                if (!ACQ_ENABLE_I) begin
                    acq_st_nxt = tws_pkg::A_IDLE;
                end else if (acq_take) begin
                    acq_st_nxt      = tws_pkg::A_RUN;
                    frames_left_nxt = (CONFIG_I.frames_per_acq == tws_pkg::FRM_RST) ?
                                      tws_pkg::FRM_ONE : CONFIG_I.frames_per_acq;
                end
            end
            tws_pkg::A_RUN: begin
                if (frame_done) begin
                    frames_left_nxt = frames_left_r - tws_pkg::FRM_ONE;
                    if (frames_left_r <= tws_pkg::FRM_ONE) begin
                        acq_st_nxt = tws_pkg::A_WAIT;
                    end
                end
            end
            default: acq_st_nxt = tws_pkg::A_IDLE;
        endcase
    end

    // ****************************************************************
    // frame state
    // ****************************************************************
    always_comb begin
        frm_st_nxt     = frm_st_r;
        lines_left_nxt = lines_left_r;
        case (frm_st_r)
            tws_pkg::F_IDLE: begin
                if (acq_st_r == tws_pkg::A_RUN) begin
                    frm_st_nxt = tws_pkg::F_WAIT;
                end
            end
            tws_pkg::F_WAIT: begin
                if (acq_st_r != tws_pkg::A_RUN) begin
                    frm_st_nxt = tws_pkg::F_IDLE;
                end else if (frm_take) begin
                    frm_st_nxt     = tws_pkg::F_RUN;
                    lines_left_nxt = (CONFIG_I.lines_per_frame == tws_pkg::CNT_RST) ?
                                     tws_pkg::CNT_ONE : CONFIG_I.lines_per_frame;
                end
            end
            tws_pkg::F_RUN: begin
                if (expo_end) begin
                    lines_left_nxt = lines_left_r - tws_pkg::CNT_ONE;
                end
                if (frame_done) begin
                    frm_st_nxt = tws_pkg::F_IDLE;
                end
            end
            default: frm_st_nxt = tws_pkg::F_IDLE;
        endcase
    end

    // ****************************************************************
    // line state
    // ****************************************************************
    always_comb begin
        lin_st_nxt  = lin_st_r;
        exp_cnt_nxt = (exp_cnt_r != tws_pkg::CNT_RST) ? exp_cnt_r - tws_pkg::CNT_ONE : exp_cnt_r;
        rd_cnt_nxt  = (rd_cnt_r != tws_pkg::CNT_RST) ? rd_cnt_r - tws_pkg::CNT_ONE : rd_cnt_r;
        case (lin_st_r)
            tws_pkg::L_IDLE: begin
                if (frm_st_r == tws_pkg::F_RUN) begin
                    lin_st_nxt = tws_pkg::L_GAP;
                end
            end
            tws_pkg::L_GAP: begin
                if (frm_st_r != tws_pkg::F_RUN) begin
                    lin_st_nxt = tws_pkg::L_IDLE;
                end else if (headroom) begin
                    lin_st_nxt = tws_pkg::L_WAIT;
                end
            end
            tws_pkg::L_WAIT: begin
                if (frm_st_r != tws_pkg::F_RUN) begin
                    lin_st_nxt = tws_pkg::L_IDLE;
                end else if (lin_take) begin
                    lin_st_nxt  = tws_pkg::L_EXPO;
                    exp_cnt_nxt = CONFIG_I.exposure_duration_setting;
                end
            end
            tws_pkg::L_EXPO: begin
                if (expo_end) begin
                    rd_cnt_nxt = tws_pkg::READOUT_LOAD;
                    lin_st_nxt = frame_done ? tws_pkg::L_IDLE : tws_pkg::L_GAP;
                end
            end
            default: lin_st_nxt = tws_pkg::L_IDLE;
        endcase
    end

    // ****************************************************************
    // status outputs
    // ****************************************************************
    always_comb begin
        wait_nxt[TA] = (acq_st_nxt == tws_pkg::A_WAIT) && hw_en[TA];
        wait_nxt[TF] = (frm_st_nxt == tws_pkg::F_WAIT) && hw_en[TF];
        wait_nxt[TL] = (lin_st_nxt == tws_pkg::L_WAIT);
        ovt_nxt[TA]  = hw_edge[TA] && (acq_st_r != tws_pkg::A_WAIT);
        ovt_nxt[TF]  = hw_edge[TF] && (frm_st_r != tws_pkg::F_WAIT);
        ovt_nxt[TL]  = hw_edge[TL] && (lin_st_r != tws_pkg::L_WAIT);
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            acq_st_r      <= tws_pkg::A_IDLE;
            frames_left_r <= tws_pkg::FRM_RST;
            frm_st_r      <= tws_pkg::F_IDLE;
            lines_left_r  <= tws_pkg::CNT_RST;
            lin_st_r      <= tws_pkg::L_IDLE;
            exp_cnt_r     <= tws_pkg::CNT_RST;
            rd_cnt_r      <= tws_pkg::CNT_RST;
            wait_r        <= {3{tws_pkg::BIT_RST}};
            ovt_r         <= {3{tws_pkg::BIT_RST}};
        end else begin
            acq_st_r      <= acq_st_nxt;
            frames_left_r <= frames_left_nxt;
            frm_st_r      <= frm_st_nxt;
            lines_left_r  <= lines_left_nxt;
            lin_st_r      <= lin_st_nxt;
            exp_cnt_r     <= exp_cnt_nxt;
            rd_cnt_r      <= rd_cnt_nxt;
            wait_r        <= wait_nxt;
            ovt_r         <= ovt_nxt;
        end
    end

    assign ACQ_WAIT_O       = wait_r[TA];
    assign FRAME_WAIT_O     = wait_r[TF];
    assign LINE_WAIT_O      = wait_r[TL];
    assign ACQ_OVERTRIG_O   = ovt_r[TA];
    assign FRAME_OVERTRIG_O = ovt_r[TF];
    assign LINE_OVERTRIG_O  = ovt_r[TL];

    // ****************************************************************
    // output line routing
    // ****************************************************************
    generate
        for (genvar g = 0; g < tws_pkg::N_OUT; g++) begin : g_out
            always_comb begin
                src_nxt[g] = src_r[g];
                if (OUTPUT_PIN_SOURCE_WE_I &&
                    (OUTPUT_PIN_SELECTOR_I == tws_pkg::OUT_SEL_W'(g))) begin
                    src_nxt[g] = OUTPUT_PIN_SOURCE_I;
                end
                case (src_r[g])
                    tws_pkg::SRC_ACQ_WAIT:   out_nxt[g] = wait_r[TA];
                    tws_pkg::SRC_FRAME_WAIT: out_nxt[g] = wait_r[TF];
                    tws_pkg::SRC_LINE_WAIT:  out_nxt[g] = wait_r[TL];
                    default:                 out_nxt[g] = 1'b0;
                endcase
            end

            always_ff @(posedge CLOCK_I) begin
                if (!RESETN_I) begin
                    src_r[g] <= tws_pkg::OUT_SRC_RST[g];
                    out_r[g] <= tws_pkg::BIT_RST;
                end else begin
                    src_r[g] <= src_nxt[g];
                    out_r[g] <= out_nxt[g];
                end
            end
        end
    endgenerate

    assign OUTPUT_LINES_O = out_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);

    a_acq_wait_enter: assert property (
        (acq_st_r == tws_pkg::A_IDLE) && ACQ_ENABLE_I && hw_en[TA] |=> ACQ_WAIT_O
    ) else $error("acquisition wait not raised on entering wait");

    a_acq_wait_fall: assert property (
        ACQ_WAIT_O && hw_edge[TA] && ACQ_ENABLE_I && (acq_st_r == tws_pkg::A_WAIT)
        |=> !ACQ_WAIT_O && (acq_st_r == tws_pkg::A_RUN)
    ) else $error("acquisition wait not dropped on accepted trigger");

    a_acq_overtrig: assert property (
        hw_edge[TA] && (acq_st_r != tws_pkg::A_WAIT) |=> ACQ_OVERTRIG_O && $stable(acq_st_r)
    ) else $error("acquisition overtrigger not reported");

    a_acq_wait_gate: assert property (
        ACQ_WAIT_O |-> $past(hw_en[TA])
    ) else $error("acquisition wait without hardware triggering");

    a_frame_wait_enter: assert property (
        (frm_st_r == tws_pkg::F_IDLE) && (acq_st_r == tws_pkg::A_RUN) && hw_en[TF]
        |=> FRAME_WAIT_O
    ) else $error("frame wait not raised on entering wait");

    a_frame_wait_fall: assert property (
        FRAME_WAIT_O && frm_take |=> !FRAME_WAIT_O ##1 !FRAME_WAIT_O
    ) else $error("frame wait not dropped on accepted trigger");

    a_frame_overtrig: assert property (
        hw_edge[TF] && (frm_st_r != tws_pkg::F_WAIT) |=> FRAME_OVERTRIG_O
    ) else $error("frame overtrigger not reported");

    a_frame_wait_gate: assert property (
        FRAME_WAIT_O |-> $past(hw_en[TF])
    ) else $error("frame wait without hardware triggering");

    a_out_default: assert property (
        !$past(RESETN_I) |-> (src_r[1] == tws_pkg::SRC_FRAME_WAIT) && !OUTPUT_LINES_O[1]
    ) else $error("output line two not defaulted to frame wait");

    a_out_route: assert property (
        $past(src_r[0]) == tws_pkg::SRC_LINE_WAIT |-> OUTPUT_LINES_O[0] == $past(LINE_WAIT_O)
    ) else $error("output line one not following its source");

    a_line_wait_fall: assert property (
        LINE_WAIT_O && lin_take |=> !LINE_WAIT_O && (lin_st_r == tws_pkg::L_EXPO)
    ) else $error("line wait not dropped on accepted trigger");

    a_line_overtrig: assert property (
        hw_edge[TL] && (lin_st_r != tws_pkg::L_WAIT) |=> LINE_OVERTRIG_O
    ) else $error("line overtrigger not reported");

    a_rise_timed: assert property (
        $rose(LINE_WAIT_O) && !width_mode |-> $past(rd_cnt_r) <= CONFIG_I.exposure_duration_setting
    ) else $error("line wait rose early in timed mode");

    a_rise_width: assert property (
        $rose(LINE_WAIT_O) && width_mode
        |-> $past(rd_cnt_r) <= CONFIG_I.max_overlap_exposure_setting
    ) else $error("line wait rose early in width mode");

    a_ovt_pulse: assert property (
        LINE_OVERTRIG_O || FRAME_OVERTRIG_O |=> !LINE_OVERTRIG_O && !FRAME_OVERTRIG_O
    ) else $error("overtrigger longer than one cycle");

    c_acq_overtrig: cover property (ACQ_OVERTRIG_O);
    c_width_rise:   cover property ($rose(LINE_WAIT_O) && width_mode);
    c_acq_done:     cover property (frame_done && (frames_left_r == tws_pkg::FRM_ONE));
    c_line_route:   cover property ($rose(OUTPUT_LINES_O[1]));

endmodule // tws_trigger_wait

// ===== tb/tws_trig_src.sv
// external trigger source model: drives the three trigger pins
// assumes the caller paces pulses by the wait outputs
`timescale 1ns/1ps
module tws_trig_src (
    input  wire logic  clk_i,
    output logic [2:0] pin_o
);
    // ****************************************************************
    // pulse driver
    // ****************************************************************
    initial pin_o = 3'h0;

    // idle low between pulses; the caller picks the hold, so width exposures
    // stay at least the overlap setting and line pulses follow the line wait
    task automatic fire(input int idx, input int hold);
        @(negedge clk_i);
        pin_o[idx] = 1'b1;
        repeat (hold) @(negedge clk_i);
        pin_o[idx] = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
endmodule // tws_trig_src

// ===== tb/tws_trigger_wait_tb.sv
// self-checking bench for the trigger wait status block
// assumes the pin model in tws_trig_src and package timing constants
`timescale 1ns/1ps
module tws_trigger_wait_tb;
    localparam int RO = tws_pkg::READOUT_CYC;
    localparam int OV = 200;
    logic              CLOCK_I = 1'b0;
    logic              RESETN_I = 1'b0;
    tws_pkg::tws_cfg_t cfg;
    logic              acq_en = 1'b0;
    logic [2:0]        pin;
    logic              sel = 1'b0;
    tws_pkg::tws_src_t src = tws_pkg::SRC_OFF;
    logic              we = 1'b0;
    logic [2:0]        w;
    logic [2:0]        ot;
    logic [1:0]        lines;
    int                ot_cnt [3] = '{0, 0, 0};
    int                error_cnt = 0;
    int                n_checks = 0;
    int                n;

    // ****************************************************************
    // design, pin model, monitors
    // ****************************************************************
    tws_trigger_wait dut (
        .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .CONFIG_I(cfg), .ACQ_ENABLE_I(acq_en),
        .EXT_ACQUISITION_START_TRIGGER_I(pin[0]), .EXT_FRAME_START_TRIGGER_I(pin[1]),
        .EXT_LINE_START_TRIGGER_I(pin[2]), .OUTPUT_PIN_SELECTOR_I(sel),
        .OUTPUT_PIN_SOURCE_I(src), .OUTPUT_PIN_SOURCE_WE_I(we), .ACQ_WAIT_O(w[0]),
        .FRAME_WAIT_O(w[1]), .LINE_WAIT_O(w[2]), .ACQ_OVERTRIG_O(ot[0]),
        .FRAME_OVERTRIG_O(ot[1]), .LINE_OVERTRIG_O(ot[2]), .OUTPUT_LINES_O(lines));
    tws_trig_src src_m (.clk_i(CLOCK_I), .pin_o(pin));

    initial begin
        forever #5 CLOCK_I = ~CLOCK_I;
    end
    // counting pulses proves each event is one cycle long
    always @(posedge CLOCK_I) begin
        for (int i = 0; i < 3; i++) if (ot[i] === 1'b1) ot_cnt[i]++;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("FAIL %s exp %0h got %0h", nm, exp, got);
            error_cnt++;
        end
    endtask
    task automatic wait_w(input int i);
        n = 0;
        while (w[i] !== 1'b1 && n < 3000) begin
            @(negedge CLOCK_I);
            n++;
        end
        chk("wait high", 16'h0001, {15'h0000, w[i]});
    endtask
    task automatic route(input logic s, input tws_pkg::tws_src_t v);
        @(negedge CLOCK_I);
        sel = s;
        src = v;
        we = 1'b1;
        @(negedge CLOCK_I);
        we = 1'b0;
        repeat (2) @(negedge CLOCK_I);
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // watchdog at 60k cycles, well beyond the roughly 7k cycles the tests need
    initial begin
        #600000;
        error_cnt++;
        complete_run();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        cfg = '{3'h7, 3'h0, tws_pkg::EXPO_TIMED, 16'h0010, 16'h00c8, 8'h01, 16'h0002};
        repeat (20) @(negedge CLOCK_I);
        RESETN_I = 1'b1;
        @(negedge CLOCK_I);
        chk("reset waits", 16'h0000, {13'h0000, w});
        chk("reset lines", 16'h0000, {14'h0000, lines});
        acq_en = 1'b1;
        wait_w(0);
        src_m.fire(1, 4);
        chk("frame overtrig", 16'h0001, 16'(ot_cnt[1]));
        src_m.fire(0, 4);
        chk("acq wait low", 16'h0000, {15'h0000, w[0]});
        wait_w(1);
        @(negedge CLOCK_I);
        chk("line2 default", 16'h0001, {15'h0000, lines[1]});
        src_m.fire(0, 4);
        chk("acq overtrig", 16'h0001, 16'(ot_cnt[0]));
        src_m.fire(1, 4);
        chk("frame wait low", 16'h0000, {15'h0000, w[1]});
        wait_w(2);
        src_m.fire(2, 4);
        chk("line wait low", 16'h0000, {15'h0000, w[2]});
        wait_w(2);
        chk("timed rise", 16'h0001, 16'(n > RO - 8 && n < RO + 8));
        src_m.fire(2, 4);
        src_m.fire(2, 4);
        chk("line overtrig", 16'h0001, 16'(ot_cnt[2]));
        wait_w(0);
        for (int s = 0; s < 4; s++) begin
            route(1'b0, tws_pkg::tws_src_t'(s));
            chk("line1 source", 16'(s == 1), {15'h0000, lines[0]});
        end
        route(1'b1, tws_pkg::SRC_OFF);
        chk("line2 source", 16'h0000, {15'h0000, lines[1]});
        acq_en = 1'b0;
        repeat (2) @(negedge CLOCK_I);
        cfg.expo_mode = tws_pkg::EXPO_TRIG_WIDTH;
        acq_en = 1'b1;
        wait_w(0);
        src_m.fire(0, 4);
        src_m.fire(1, 4);
        wait_w(2);
        src_m.fire(2, 300);
        wait_w(2);
        chk("width rise", 16'h0001, 16'(n > RO - OV - 4 && n < RO - OV + 12));
        src_m.fire(2, 300);
        wait_w(0);
        acq_en = 1'b0;
        repeat (2) @(negedge CLOCK_I);
        cfg.hw_trig_en = 3'h0;
        acq_en = 1'b1;
        n = 0;
        repeat (3000) begin
            @(negedge CLOCK_I);
            n += int'(w[0] | w[1]);
        end
        chk("waits gated", 16'h0000, 16'(n));
        complete_run();
    end
endmodule // tws_trigger_wait_tb
